// file: hdl/actr_top.sv
// execute stage of the accumulator-to-control transfer group
// assumes core state arrives on inputs and a classic wishbone master
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - code 22b copies A to port structure control three, one cycle
// - interrupt control one load copies A, interrupt control two untouched
// - code 218 copies A to interrupt control two, no skip
// - code 202 copies A to serial control one
// - wakeup loads copy A to wakeup controls zero, one, two
// - codes 2b0-2bf store A at data pointer and X ^= low nibble
// - code 216 copies A to clock mode register
// - timer enable load copies only A bit 0
// - code 235 loads B:A into prescaler count and reload together
// - pull-up loads copy A to pull-up control zero or one
// - converter loads copy A to converter control one, two, three
// - code 23f loads B:A into timer one reload
// - code 23b loads B:A into timer three reload
// - code 209 copies A bit 0 to clock source select
// - code 238 loads B:A into serial shift register
module actr_top
   import actr_pkg::*;
(
   // clock and reset
   input  wire logic            clk_i,
   input  wire logic            rst_n_i,
   // core side
   input  wire logic [9:0]      instr_i,
   input  wire logic            instr_vld_i,
   input  wire logic [3:0]      acc_i,
   input  wire logic [3:0]      regb_i,
   input  wire logic [3:0]      x_i,
   input  wire logic [DP_W-1:0] data_pointer_i,
   output logic                 x_wr_o,
   output logic [3:0]           x_o,
   output logic                 ram_we_o,
   output logic [DP_W-1:0]      ram_addr_o,
   output logic [3:0]           ram_wdata_o,
   // control registers
   output logic [3:0]           port_struct_ctrl_three_o,
   output logic [3:0]           int_ctrl_one_o,
   output logic [3:0]           int_ctrl_two_o,
   output logic [3:0]           serial_ctrl_one_o,
   output logic [3:0]           wakeup_ctrl_zero_o,
   output logic [3:0]           wakeup_ctrl_one_o,
   output logic [3:0]           wakeup_ctrl_two_o,
   output logic [3:0]           clock_mode_reg_o,
   output logic [3:0]           pullup_ctrl_zero_o,
   output logic [3:0]           pullup_ctrl_one_o,
   output logic [3:0]           conv_ctrl_one_o,
   output logic [3:0]           conv_ctrl_two_o,
   output logic [3:0]           conv_ctrl_three_o,
   output logic                 timer_enable_bit_o,
   output logic                 clock_source_select_o,
   output logic [7:0]           prescaler_reload_o,
   output logic [7:0]           prescaler_count_o,
   output logic                 prescaler_load_o,
   output logic [7:0]           reload_timer_one_o,
   output logic [7:0]           reload_timer_three_o,
   output logic [7:0]           serial_shift_o,
   // wishbone slave
   input  wire logic            wb_cyc_i,
   input  wire logic            wb_stb_i,
   input  wire logic            wb_we_i,
   input  wire logic [7:0]      wb_adr_i,
   input  wire logic [3:0]      wb_sel_i,
   input  wire logic [31:0]     wb_dat_i,
   output logic [31:0]          wb_dat_o,
   output logic                 wb_ack_o
);

   // ----------------------------------------
   // decode
   // ----------------------------------------
   actr_dec_if dif ();
   assign dif.word = instr_i;
   assign dif.vld  = instr_vld_i;

   actr_decode u_dec (
      .d (dif)
   );

   logic     en_q, en_d;
   logic     ex;
   actr_op_t op;
   assign op = dif.op;
   assign ex = en_q && (op != OP_NONE);

   // ----------------------------------------
   // destination registers
   // ----------------------------------------
   logic [3:0]      nib_q  [N_NIB];
   logic [3:0]      nib_d  [N_NIB];
   logic [7:0]      pair_q [N_PAIR];
   logic [7:0]      pair_d [N_PAIR];
   logic            pa_q, pa_d, rg_q, rg_d, psl_q, psl_d;
   logic            xw_q, xw_d, rw_q, rw_d;
   logic [3:0]      x_q, x_d, rd_q, rd_d;
   logic [DP_W-1:0] ra_q, ra_d;
   logic [7:0]      cnt_q, cnt_d;
   actr_op_t        last_q, last_d;

   always_comb
   begin
      nib_d  = nib_q;
      pair_d = pair_q;
      pa_d   = pa_q;
      rg_d   = rg_q;
      psl_d  = 1'b0;
      xw_d   = 1'b0;
      rw_d   = 1'b0;
      x_d    = x_q;
      rd_d   = rd_q;
      ra_d   = ra_q;
      cnt_d  = cnt_q;
      last_d = last_q;
      if (ex)
      begin
         cnt_d  = cnt_q + 8'h01;
         last_d = op;
         if (op >= OP_PS3 && op <= OP_Q3)
            nib_d[4'(op - OP_PS3)] = acc_i;
         case (op)
            OP_PA: pa_d = acc_i[0];
            OP_RG: rg_d = acc_i[0];
            OP_PS:
            begin
               pair_d[P_PSR] = {regb_i, acc_i};
               pair_d[P_PSC] = {regb_i, acc_i};
               psl_d         = 1'b1;
            end
            OP_R1: pair_d[P_R1] = {regb_i, acc_i};
            OP_R3: pair_d[P_R3] = {regb_i, acc_i};
            OP_SI: pair_d[P_SI] = {regb_i, acc_i};
            OP_TMA:
            begin
               rw_d = 1'b1;
               ra_d = data_pointer_i;
               rd_d = acc_i;
               xw_d = 1'b1;
               x_d  = x_i ^ dif.imm;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < N_NIB; i++)
            nib_q[i] <= NIB_RST;
         for (int i = 0; i < N_PAIR; i++)
            pair_q[i] <= PAIR_RST;
         pa_q   <= 1'b0;
         rg_q   <= 1'b0;
         psl_q  <= 1'b0;
         xw_q   <= 1'b0;
         rw_q   <= 1'b0;
         x_q    <= 4'h0;
         rd_q   <= 4'h0;
         ra_q   <= '0;
         cnt_q  <= 8'h00;
         last_q <= OP_NONE;
      end
      else
      begin
         nib_q  <= nib_d;
         pair_q <= pair_d;
         pa_q   <= pa_d;
         rg_q   <= rg_d;
         psl_q  <= psl_d;
         xw_q   <= xw_d;
         rw_q   <= rw_d;
         x_q    <= x_d;
         rd_q   <= rd_d;
         ra_q   <= ra_d;
         cnt_q  <= cnt_d;
         last_q <= last_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign port_struct_ctrl_three_o = nib_q[0];
   assign int_ctrl_one_o           = nib_q[1];
   assign int_ctrl_two_o           = nib_q[2];
   assign serial_ctrl_one_o        = nib_q[3];
   assign wakeup_ctrl_zero_o       = nib_q[4];
   assign wakeup_ctrl_one_o        = nib_q[5];
   assign wakeup_ctrl_two_o        = nib_q[6];
   assign clock_mode_reg_o         = nib_q[7];
   assign pullup_ctrl_zero_o       = nib_q[8];
   assign pullup_ctrl_one_o        = nib_q[9];
   assign conv_ctrl_one_o          = nib_q[10];
   assign conv_ctrl_two_o          = nib_q[11];
   assign conv_ctrl_three_o        = nib_q[12];
   assign timer_enable_bit_o       = pa_q;
   assign clock_source_select_o    = rg_q;
   assign prescaler_reload_o       = pair_q[P_PSR];
   assign prescaler_count_o        = pair_q[P_PSC];
   assign prescaler_load_o         = psl_q;
   assign reload_timer_one_o       = pair_q[P_R1];
   assign reload_timer_three_o     = pair_q[P_R3];
   assign serial_shift_o           = pair_q[P_SI];
   assign x_wr_o                   = xw_q;
   assign x_o                      = x_q;
   assign ram_we_o                 = rw_q;
   assign ram_addr_o               = ra_q;
   assign ram_wdata_o              = rd_q;

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   logic        ack_q, ack_d;
   logic [31:0] dat_q, dat_d, rmux;
   logic [7:0]  ofs;
   assign ofs = wb_adr_i - A_NIB;

   always_comb
   begin
      rmux = 32'h0000_0000;
      if (wb_adr_i == A_CTRL)
         rmux[CTRL_EN] = en_q;
      else if (wb_adr_i == A_STAT)
         rmux = {19'h0, 5'(last_q), cnt_q};
      else if (wb_adr_i[1:0] == 2'b00 && wb_adr_i >= A_NIB
               && wb_adr_i < A_NIB + 8'(4 * N_NIB))
         rmux[3:0] = nib_q[4'(ofs[7:2])];
      else if (wb_adr_i[1:0] == 2'b00 && wb_adr_i >= A_PAIR
               && wb_adr_i < A_PAIR + 8'(4 * N_PAIR))
         rmux[7:0] = pair_q[3'(wb_adr_i[4:2])];
      else if (wb_adr_i == A_BITS)
         rmux[1:0] = {rg_q, pa_q};
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      dat_d = ack_d ? rmux : dat_q;
      en_d  = en_q;
      if (wb_cyc_i && wb_stb_i && wb_we_i && ack_q
          && wb_adr_i == A_CTRL && wb_sel_i[0])
         en_d = wb_dat_i[CTRL_EN];
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         en_q  <= CTRL_RST;
      end
      else
      begin
         ack_q <= ack_d;
         dat_q <= dat_d;
         en_q  <= en_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   logic store_go;
   assign store_go = en_q && instr_vld_i && instr_i[9:4] == C_TMA_HI;

   chk_ps3_load: assert property (
      ex && op == OP_PS3 |=> port_struct_ctrl_three_o == $past(acc_i))
      else $error("port structure three not loaded");
   chk_int_two: assert property (
      en_q && instr_vld_i && instr_i == C_I2
      |=> int_ctrl_two_o == $past(acc_i))
      else $error("interrupt control two not loaded");
   chk_int_one: assert property (
      ex && op == OP_I1 |=> int_ctrl_one_o == $past(acc_i)
      && int_ctrl_two_o == $past(int_ctrl_two_o))
      else $error("interrupt control one wrong");
   chk_serial_one: assert property (
      ex && op == OP_J1 |=> serial_ctrl_one_o == $past(acc_i))
      else $error("serial control one not loaded");
   chk_wakeup_two: assert property (
      en_q && instr_vld_i && instr_i == C_K2
      |=> wakeup_ctrl_two_o == $past(acc_i))
      else $error("wakeup control two not loaded");
   chk_store_xor: assert property (
      ex && op == OP_TMA |=> ram_we_o && x_wr_o
      && ram_wdata_o == $past(acc_i)
      && ram_addr_o == $past(data_pointer_i)
      && x_o == ($past(x_i) ^ $past(instr_i[3:0]))
      ##1 ram_we_o == $past(store_go))
      else $error("memory store or x update wrong");
   chk_clock_mode: assert property (
      ex && op == OP_MR |=> clock_mode_reg_o == $past(acc_i))
      else $error("clock mode not loaded");
   chk_timer_bit: assert property (
      ex && op == OP_PA |=> timer_enable_bit_o == $past(acc_i[0]))
      else $error("timer enable bit wrong");
   chk_prescaler_pair: assert property (
      ex && op == OP_PS |=> prescaler_load_o
      && prescaler_reload_o == {$past(regb_i), $past(acc_i)}
      && prescaler_count_o == {$past(regb_i), $past(acc_i)})
      else $error("prescaler pair wrong");
   chk_pullup_zero: assert property (
      ex && op == OP_PU0 |=> pullup_ctrl_zero_o == $past(acc_i))
      else $error("pull-up zero not loaded");
   chk_conv_three: assert property (
      en_q && instr_vld_i && instr_i == C_Q3
      |=> conv_ctrl_three_o == $past(acc_i))
      else $error("converter three not loaded");
   chk_reload_one: assert property (
      ex && op == OP_R1
      |=> reload_timer_one_o == {$past(regb_i), $past(acc_i)})
      else $error("timer one reload wrong");
   chk_reload_three: assert property (
      ex && op == OP_R3
      |=> reload_timer_three_o == {$past(regb_i), $past(acc_i)})
      else $error("timer three reload wrong");
   chk_clock_source: assert property (
      ex && op == OP_RG |=> clock_source_select_o == $past(acc_i[0]))
      else $error("clock source bit wrong");
   chk_serial_shift: assert property (
      ex && op == OP_SI
      |=> serial_shift_o == {$past(regb_i), $past(acc_i)})
      else $error("serial shift register wrong");
   chk_decode_match: assert property (
      instr_vld_i |-> (op == OP_TMA) == (instr_i[9:4] == C_TMA_HI))
      else $error("store decode mismatch");
   chk_idle_hold: assert property (
      !ex |=> $stable(serial_shift_o) && $stable(clock_mode_reg_o)
      && !ram_we_o && !prescaler_load_o)
      else $error("register changed without instruction");

   cov_store: cover property (ex && op == OP_TMA ##1 ex && op == OP_TMA);
   cov_pair: cover property (ex && op == OP_PS);
   cov_bus_rd: cover property (wb_cyc_i && wb_stb_i && !wb_we_i ##1 ack_q);

endmodule // actr_top
`default_nettype wire

// file: common/actr_pkg.sv
// constants, op codes and register map of the transfer decoder
// assumes a core that presents one 10-bit instruction word per cycle
package actr_pkg;

   // ----------------------------------------
   // widths
   // ----------------------------------------
   localparam int unsigned DP_W   = 6;
   localparam int unsigned N_NIB  = 13;
   localparam int unsigned N_PAIR = 5;

   // ----------------------------------------
   // instruction codes
   // ----------------------------------------
   localparam logic [9:0] C_PS3 = 10'h22b;
   localparam logic [9:0] C_I1  = 10'h217;
   localparam logic [9:0] C_I2  = 10'h218;
   localparam logic [9:0] C_J1  = 10'h202;
   localparam logic [9:0] C_K0  = 10'h21b;
   localparam logic [9:0] C_K1  = 10'h214;
   localparam logic [9:0] C_K2  = 10'h215;
   localparam logic [9:0] C_MR  = 10'h216;
   localparam logic [9:0] C_PU0 = 10'h22d;
   localparam logic [9:0] C_PU1 = 10'h22e;
   localparam logic [9:0] C_Q1  = 10'h204;
   localparam logic [9:0] C_Q2  = 10'h205;
   localparam logic [9:0] C_Q3  = 10'h206;
   localparam logic [9:0] C_PA  = 10'h2aa;
   localparam logic [9:0] C_PS  = 10'h235;
   localparam logic [9:0] C_R1  = 10'h23f;
   localparam logic [9:0] C_R3  = 10'h23b;
   localparam logic [9:0] C_RG  = 10'h209;
   localparam logic [9:0] C_SI  = 10'h238;
   localparam logic [5:0] C_TMA_HI = 6'h2b;

   // ----------------------------------------
   // operations, nibble targets first in index order
   // ----------------------------------------
   typedef enum logic [4:0] {
      OP_NONE, OP_PS3, OP_I1, OP_I2, OP_J1, OP_K0, OP_K1, OP_K2,
      OP_MR, OP_PU0, OP_PU1, OP_Q1, OP_Q2, OP_Q3,
      OP_PA, OP_PS, OP_R1, OP_R3, OP_RG, OP_SI, OP_TMA
   } actr_op_t;

   // pair slots
   localparam logic [2:0] P_PSR = 3'h0;
   localparam logic [2:0] P_PSC = 3'h1;
   localparam logic [2:0] P_R1  = 3'h2;
   localparam logic [2:0] P_R3  = 3'h3;
   localparam logic [2:0] P_SI  = 3'h4;

   // ----------------------------------------
   // bus map and reset values
   // ----------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_NIB  = 8'h40;
   localparam logic [7:0] A_PAIR = 8'h80;
   localparam logic [7:0] A_BITS = 8'h94;
   localparam int unsigned CTRL_EN = 0;
   localparam logic CTRL_RST = 1'b1;
   localparam logic [3:0] NIB_RST = 4'h0;
   localparam logic [7:0] PAIR_RST = 8'h00;

   function automatic actr_op_t actr_decode(input logic [9:0] w);
      actr_op_t op;
      op = OP_NONE;
      case (w)
         C_PS3: op = OP_PS3;
         C_I1:  op = OP_I1;
         C_I2:  op = OP_I2;
         C_J1:  op = OP_J1;
         C_K0:  op = OP_K0;
         C_K1:  op = OP_K1;
         C_K2:  op = OP_K2;
         C_MR:  op = OP_MR;
         C_PU0: op = OP_PU0;
         C_PU1: op = OP_PU1;
         C_Q1:  op = OP_Q1;
         C_Q2:  op = OP_Q2;
         C_Q3:  op = OP_Q3;
         C_PA:  op = OP_PA;
         C_PS:  op = OP_PS;
         C_R1:  op = OP_R1;
         C_R3:  op = OP_R3;
         C_RG:  op = OP_RG;
         C_SI:  op = OP_SI;
         default:
            if (w[9:4] == C_TMA_HI)
               op = OP_TMA;
      endcase
      return op;
   endfunction

endpackage

// file: common/actr_dec_if.sv
// decode path between the execute top and its decoder
// assumes both ends sit in one clock domain
`timescale 1ns/1ps
`default_nettype none
interface actr_dec_if;
   import actr_pkg::*;
   logic [9:0] word;
   logic       vld;
   actr_op_t   op;
   logic [3:0] imm;
   modport dec (input word, input vld, output op, output imm);
   modport exe (output word, output vld, input op, input imm);
endinterface
`default_nettype wire

// file: hdl/actr_decode.sv
// instruction decoder for the transfer group
// assumes the word is stable for the cycle in which vld is high
`timescale 1ns/1ps
`default_nettype none
module actr_decode
   import actr_pkg::*;
(
   // decode path
   actr_dec_if.dec d
);

   // ----------------------------------------
   // decode
   // ----------------------------------------
   always_comb
   begin
      d.op  = OP_NONE;
      d.imm = d.word[3:0];
      if (d.vld)
         d.op = actr_decode(d.word);
   end

endmodule // actr_decode
`default_nettype wire

// file: testbench/actr_prog_mem.sv
// program memory model: one 10-bit instruction word per index
// assumes the bench steps the index, one word per executed cycle
`timescale 1ns/1ps
`default_nettype none
module actr_prog_mem
(
   // fetch
   input  wire logic [4:0] pc_i,
   output logic      [9:0] word_o
);
   // ----------------------------------------
   // words: 13 nibble loads, pairs, bits, stores, strays
   // ----------------------------------------
   localparam logic [9:0] ROM [25] = '{
      10'h22b, 10'h217, 10'h218, 10'h202, 10'h21b, 10'h214, 10'h215,
      10'h216, 10'h22d, 10'h22e, 10'h204, 10'h205, 10'h206,
      10'h235, 10'h23f, 10'h23b, 10'h238, 10'h2aa, 10'h209,
      10'h2b0, 10'h2bf, 10'h2b5, 10'h22a, 10'h32b, 10'h0b5};
   // words past the table read as a stray code
   assign word_o = (pc_i < 5'd25) ? ROM[pc_i] : 10'h3ff;
endmodule // actr_prog_mem
`default_nettype wire

// file: testbench/actr_top_tb.sv
// self-checking bench for the transfer decoder
// assumes program memory model and classic wishbone master tasks
`timescale 1ns/1ps
`default_nettype none
module actr_top_tb;
   import actr_pkg::*;
   // ----------------------------------------
   // stimulus and observation
   // ----------------------------------------
   logic            clk_i   = 1'b0;
   logic            rst_n_i = 1'b0;
   logic [4:0]      pc      = '0;
   logic            vld     = 1'b0;
   logic [3:0]      acc     = '0;
   logic [3:0]      regb    = '0;
   logic [3:0]      xv      = '0;
   logic [DP_W-1:0] dp      = '0;
   logic            cyc     = 1'b0;
   logic            stb     = 1'b0;
   logic            we      = 1'b0;
   logic [7:0]      adr     = '0;
   logic [31:0]     wdat    = '0;
   logic [31:0]     rdat;
   logic [31:0]     dat_o;
   logic [9:0]      word;
   logic            x_wr, ram_we, ps_ld, te_bit, rg_bit, ack;
   logic [3:0]      x_new, wdata;
   logic [DP_W-1:0] raddr;
   logic [3:0]      nib [13];
   logic [7:0]      pair [5];
   logic [3:0]      exp_nib [13];
   localparam logic [3:0] STJ [3] = '{4'h0, 4'hf, 4'h5};
   int              mismatches = 0;
   int              checks = 0;

   always #25 clk_i = ~clk_i;

   actr_prog_mem u_actr_prog_mem (.pc_i(pc), .word_o(word));

   actr_top u_actr_top (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(word),
      .instr_vld_i(vld), .acc_i(acc), .regb_i(regb), .x_i(xv),
      .data_pointer_i(dp), .x_wr_o(x_wr), .x_o(x_new),
      .ram_we_o(ram_we), .ram_addr_o(raddr), .ram_wdata_o(wdata),
      .port_struct_ctrl_three_o(nib[0]), .int_ctrl_one_o(nib[1]),
      .int_ctrl_two_o(nib[2]), .serial_ctrl_one_o(nib[3]),
      .wakeup_ctrl_zero_o(nib[4]), .wakeup_ctrl_one_o(nib[5]),
      .wakeup_ctrl_two_o(nib[6]), .clock_mode_reg_o(nib[7]),
      .pullup_ctrl_zero_o(nib[8]), .pullup_ctrl_one_o(nib[9]),
      .conv_ctrl_one_o(nib[10]), .conv_ctrl_two_o(nib[11]),
      .conv_ctrl_three_o(nib[12]), .timer_enable_bit_o(te_bit),
      .clock_source_select_o(rg_bit), .prescaler_reload_o(pair[0]),
      .prescaler_count_o(pair[1]), .prescaler_load_o(ps_ld),
      .reload_timer_one_o(pair[2]), .reload_timer_three_o(pair[3]),
      .serial_shift_o(pair[4]), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [31:0] e, g);
      checks++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // one instruction, outputs looked at just after the taking edge
   task automatic exec(input int i, input logic [3:0] a, b, x,
                       input logic [DP_W-1:0] d);
      @(posedge clk_i);
      pc <= 5'(i); acc <= a; regb <= b; xv <= x; dp <= d; vld <= 1'b1;
      @(posedge clk_i);
      vld <= 1'b0;
      #1;
   endtask

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1)
      begin
         mismatches++;
         end_sim();
      end
      else
      begin
         rdat = dat_o;
         cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
         @(posedge clk_i);
      end
   endtask

   initial
   begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      end_sim();
   end

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      wb(1'b0, A_CTRL, 32'h0);
      chk("ctrl reset", 32'h1, rdat);
      foreach (nib[k]) chk("nib reset", 0, nib[k]);
      for (int i = 0; i < 13; i++)
      begin
         exp_nib[i] = 4'(i + 3);
         exec(i, exp_nib[i], 4'h0, 4'h0, '0);
         chk("nib", exp_nib[i], nib[i]);
      end
      foreach (nib[k]) chk("nib keep", exp_nib[k], nib[k]);
      for (int i = 0; i < 13; i++)
      begin
         wb(1'b0, 8'(A_NIB + 4 * i), 32'h0);
         chk("nib bus", exp_nib[i], rdat);
      end
      wb(1'b0, 8'h3c, 32'h0);
      chk("unmapped", 0, rdat);
      wb(1'b1, A_NIB, 32'h5);
      chk("ro nib", exp_nib[0], nib[0]);
      exec(13, 4'h6, 4'hc, 4'h0, '0);
      chk("ps reload", 8'hc6, pair[0]);
      chk("ps count", 8'hc6, pair[1]);
      chk("ps load", 1, ps_ld);
      for (int i = 14; i < 17; i++)
      begin
         exec(i, 4'(i), 4'(~i), 4'h0, '0);
         chk("pair", {4'(~i), 4'(i)}, pair[i - 12]);
      end
      chk("ps load end", 0, ps_ld);
      wb(1'b0, 8'(A_PAIR + 16), 32'h0);
      chk("pair bus", 32'hf0, rdat);
      for (int v = 0; v < 4; v++)
      begin
         exec(17 + v / 2, (v % 2) ? 4'he : 4'h1, 4'h0, 4'h0, '0);
         chk("bit", (v % 2) ? 0 : 1, (v < 2) ? te_bit : rg_bit);
      end
      for (int i = 0; i < 3; i++)
      begin
         exec(19 + i, 4'(5 * i + 2), 4'h0, 4'ha, 6'(9 * i + 4));
         chk("ram we", 1, ram_we);
         chk("ram adr", 9 * i + 4, raddr);
         chk("ram data", 5 * i + 2, wdata);
         chk("x wr", 1, x_wr);
         chk("x", 4'ha ^ STJ[i], x_new);
      end
      wb(1'b0, A_STAT, 32'h0);
      chk("status", {19'h0, 5'(OP_TMA), 8'd24}, rdat);
      @(posedge clk_i);
      pc <= 5'd19; acc <= 4'h3; xv <= 4'h6; dp <= 6'h21; vld <= 1'b1;
      @(posedge clk_i);
      pc <= 5'd21; acc <= 4'hc; dp <= 6'h05;
      #1 chk("b2b store", 4'h3, wdata);
      @(posedge clk_i);
      vld <= 1'b0;
      #1 chk("b2b we", 1, ram_we);
      chk("b2b adr", 6'h05, raddr);
      chk("b2b data", 4'hc, wdata);
      chk("b2b x", 4'h3, x_new);
      for (int i = 22; i < 25; i++)
      begin
         exec(i, 4'hf, 4'hf, 4'h0, '0);
         chk("stray we", 0, ram_we);
         chk("stray x", 0, x_wr);
      end
      foreach (nib[k]) chk("stray keep", exp_nib[k], nib[k]);
      wb(1'b1, A_CTRL, 32'h0);
      exec(0, 4'h9, 4'h0, 4'h0, '0);
      chk("disabled", exp_nib[0], nib[0]);
      wb(1'b1, A_CTRL, 32'h1);
      exec(0, 4'h9, 4'h0, 4'h0, '0);
      chk("enabled", 4'h9, nib[0]);
      @(posedge clk_i);
      pc <= 5'd1; acc <= 4'h7; vld <= 1'b1;
      @(posedge clk_i);
      acc <= 4'h8;
      #1 chk("b2b first", 4'h7, nib[1]);
      @(posedge clk_i);
      vld <= 1'b0;
      #1 chk("b2b second", 4'h8, nib[1]);
      end_sim();
   end
endmodule // actr_top_tb
`default_nettype wire
